// ### drtc_defines.svh
// Constants for the row and synchronous memory timing configuration block.
// Assumes byte-wide configuration registers reached at the listed indexes.
// Overview of operation
// - Page/EDO row: map code 00 disables row
// - Synchronous row: four distinct mapping schemes
// - Type field: page, EDO, registered, unbuffered
// - Upper boundary nibble gives address bits 31-28
// - Per-row density bit selects 256Mbit addressing
// - Per-row bank bit: two or four banks
// - Row-to-column delay three or two clocks
// - Separate enable picks delay and latency sources
// - Command delay bit adds one clock when clear
// - Row change page hit adds one clock
// - Data spacing keeps four data periods
// - Read pipe clock delay zero to three ns
// - Read pipe adds input register stage
// - Command/write pipe stage on early clock
// - Output pipe adds data output stage
// - Lower boundary byte holds bits 27-20
`ifndef DRTC_DEFINES_SVH
`define DRTC_DEFINES_SVH
`define DRTC_OFF_ROW7_LOW 8'h6E
`define DRTC_OFF_ROW7_HIGH 8'h6F
`define DRTC_OFF_DENSITY 8'h70
`define DRTC_OFF_BANKS 8'h71
`define DRTC_OFF_FAST 8'h72
`define DRTC_OFF_PIPE 8'h73
`define DRTC_OFF_LATENCY 8'h48
`define DRTC_RESET_VALUE 8'h00
`define DRTC_FAST_MASK 8'hC7
`define DRTC_PIPE_MASK 8'h1F
`define DRTC_LATENCY_MASK 8'h10
`define DRTC_FAST_RCD_SEL 7
`define DRTC_FAST_SEP_EN 6
`define DRTC_FAST_CMD_DLY_N 2
`define DRTC_FAST_ROW_CHG 1
`define DRTC_FAST_SPACING 0
`define DRTC_PIPE_DLY_HI 4
`define DRTC_PIPE_DLY_LO 3
`define DRTC_PIPE_READ 2
`define DRTC_PIPE_CMD 1
`define DRTC_PIPE_OUT 0
`define DRTC_LAT_BIT 4
`define DRTC_RCD_SLOW 3
`define DRTC_RCD_FAST 2
`define DRTC_RCD_DEFAULT 3
`define DRTC_SPACING_PERIODS 4
`define DRTC_CLOCK_PERIOD_NS 10
`define DRTC_TAP_COUNT 4
`endif

// ### drtc_pkg.sv
// Types shared by the timing configuration block and its helpers.
// Assumes the defines header is compiled alongside.
package drtc_pkg;
  typedef enum logic [1:0] {
    DRTC_FAST_PAGE,
    DRTC_EDO,
    DRTC_REG_SYNC,
    DRTC_UNBUF_SYNC
  } drtc_mem_type_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } drtc_bus_req_t;

  typedef struct packed {
    logic [1:0] row_sel;
    logic [2:0] row;
    logic page_hit;
    logic start;
  } drtc_access_t;

  typedef struct packed {
    logic map_enable;
    logic sync_mode;
    logic [1:0] map_scheme;
    drtc_mem_type_t mem_type;
    logic [11:0] top_addr;
    logic dens_256;
    logic four_banks;
  } drtc_row_cfg_t;
endpackage : drtc_pkg

// ### drtc_delay_line.sv
// Fine delay tap select for the read pipe capture clock.
// Assumes the tap code is a static configuration value.
`timescale 1ns/100ps
module drtc_delay_line #(
  parameter int TAPS = 4
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic [1:0] tap_i,
  output logic [TAPS-1:0] tap_onehot_o
);
  logic [TAPS-1:0] next_tap_onehot;
  genvar g;
  generate
    for (g = 0; g < TAPS; g++) begin : gen_tap
      assign next_tap_onehot[g] = enable_i && (tap_i == 2'(g));
    end
  endgenerate
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tap_onehot_o <= '0;
    end else begin
      tap_onehot_o <= next_tap_onehot;
    end
  end
endmodule : drtc_delay_line

// ### drtc_pipe_stage.sv
// Optional register stage: bypassed or one clock of delay.
// Assumes the enable changes only while the memory path is idle.
`timescale 1ns/100ps
module drtc_pipe_stage #(
  parameter int WIDTH = 64
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage <= '0;
    end else begin
      stage <= data_i;
    end
  end
  assign data_o = enable_i ? stage : data_i;
endmodule : drtc_pipe_stage

// ### drtc_timing_config.sv
// Row configuration and synchronous memory timing control.
// Assumes a same-clock register port and an access request from the memory sequencer.
`timescale 1ns/100ps
`include "drtc_defines.svh"
module drtc_timing_config #(
  parameter int DATA_W = 64,
  parameter int CTRL_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire drtc_pkg::drtc_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire drtc_pkg::drtc_access_t access_i,
  input wire logic [2:0] query_row_i,
  input wire logic [DATA_W-1:0] mem_data_in_i,
  input wire logic [DATA_W-1:0] write_data_i,
  input wire logic [CTRL_W-1:0] command_i,
  input wire logic [CTRL_W-1:0] mem_ctrl_i,
  output drtc_pkg::drtc_row_cfg_t row_cfg_o,
  output drtc_pkg::drtc_row_cfg_t row7_cfg_o,
  output logic [2:0] rcd_clocks_o,
  output logic column_latency_o,
  output logic [CTRL_W-1:0] seq_command_o,
  output logic seq_command_valid_o,
  output logic access_grant_o,
  output logic [DATA_W-1:0] read_data_o,
  output logic [DATA_W-1:0] mem_data_out_o,
  output logic [CTRL_W-1:0] mem_ctrl_o,
  output logic [3:0] read_tap_o,
  output logic early_clock_sel_o
);
  import drtc_pkg::*;

  logic [7:0] row7_low;
  logic [7:0] row7_high;
  logic [7:0] row_density_bits;
  logic [7:0] row_bank_count_bits;
  logic [7:0] fast_clock_timing_reg;
  logic [7:0] pipe_ctrl;
  logic [7:0] latency_reg;

  // Address decode
  wire hit_row7_low = bus_i.addr == `DRTC_OFF_ROW7_LOW;
  wire hit_row7_high = bus_i.addr == `DRTC_OFF_ROW7_HIGH;
  wire hit_density = bus_i.addr == `DRTC_OFF_DENSITY;
  wire hit_banks = bus_i.addr == `DRTC_OFF_BANKS;
  wire hit_fast = bus_i.addr == `DRTC_OFF_FAST;
  wire hit_pipe = bus_i.addr == `DRTC_OFF_PIPE;
  wire hit_latency = bus_i.addr == `DRTC_OFF_LATENCY;

  logic [7:0] next_rdata;
  always_comb begin
    if (!bus_i.rd) begin
      next_rdata = 8'h00;
    end else if (hit_row7_low) begin
      next_rdata = row7_low;
    end else if (hit_row7_high) begin
      next_rdata = row7_high;
    end else if (hit_density) begin
      next_rdata = row_density_bits;
    end else if (hit_banks) begin
      next_rdata = row_bank_count_bits;
    end else if (hit_fast) begin
      next_rdata = fast_clock_timing_reg;
    end else if (hit_pipe) begin
      next_rdata = pipe_ctrl;
    end else if (hit_latency) begin
      next_rdata = latency_reg;
    end else begin
      next_rdata = 8'h00;
    end
  end

  // Write enables; reserved bits are masked on write so they always read zero
  wire wr_row7_low = bus_i.wr && hit_row7_low;
  wire wr_row7_high = bus_i.wr && hit_row7_high;
  wire wr_density = bus_i.wr && hit_density;
  wire wr_banks = bus_i.wr && hit_banks;
  wire wr_fast = bus_i.wr && hit_fast;
  wire wr_pipe = bus_i.wr && hit_pipe;
  wire wr_latency = bus_i.wr && hit_latency;

  // Read data stands for one cycle after each cycle with rd set, then drops back to zero
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row7_low <= `DRTC_RESET_VALUE;
    end else if (wr_row7_low) begin
      row7_low <= bus_i.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row7_high <= `DRTC_RESET_VALUE;
    end else if (wr_row7_high) begin
      row7_high <= bus_i.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_density_bits <= `DRTC_RESET_VALUE;
    end else if (wr_density) begin
      row_density_bits <= bus_i.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_bank_count_bits <= `DRTC_RESET_VALUE;
    end else if (wr_banks) begin
      row_bank_count_bits <= bus_i.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fast_clock_timing_reg <= `DRTC_RESET_VALUE;
    end else if (wr_fast) begin
      fast_clock_timing_reg <= bus_i.wdata & `DRTC_FAST_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pipe_ctrl <= `DRTC_RESET_VALUE;
    end else if (wr_pipe) begin
      pipe_ctrl <= bus_i.wdata & `DRTC_PIPE_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latency_reg <= `DRTC_RESET_VALUE;
    end else if (wr_latency) begin
      latency_reg <= bus_i.wdata & `DRTC_LATENCY_MASK;
    end
  end

  // Row 7 decode, shared by the live-row lookup when only row 7 is stored
  function automatic drtc_row_cfg_t decode_row(input logic [7:0] low, input logic [7:0] high,
                                               input logic dens, input logic banks);
    drtc_row_cfg_t c;
    c.mem_type = drtc_mem_type_t'(high[5:4]);
    c.sync_mode = high[5];
    c.map_scheme = high[7:6];
    c.map_enable = high[5] | (high[7:6] != 2'b00);
    c.top_addr = {high[3:0], low};
    c.dens_256 = dens;
    c.four_banks = banks;
    return c;
  endfunction : decode_row

  wire drtc_row_cfg_t row7_dec = decode_row(row7_low, row7_high, row_density_bits[7], row_bank_count_bits[7]);
  // Rows below 7 keep their type and bound elsewhere; only density and bank bits apply here
  wire drtc_row_cfg_t query_dec = (query_row_i == 3'h7) ? row7_dec :
    decode_row(8'h00, 8'h00, row_density_bits[query_row_i], row_bank_count_bits[query_row_i]);

  wire sep_en = fast_clock_timing_reg[`DRTC_FAST_SEP_EN];
  wire [2:0] rcd_sel = fast_clock_timing_reg[`DRTC_FAST_RCD_SEL] ? 3'(`DRTC_RCD_FAST) : 3'(`DRTC_RCD_SLOW);
  wire [2:0] next_rcd = sep_en ? rcd_sel : 3'(`DRTC_RCD_DEFAULT);
  wire next_latency = sep_en & latency_reg[`DRTC_LAT_BIT];
  wire cmd_delay_en = !fast_clock_timing_reg[`DRTC_FAST_CMD_DLY_N];
  wire row_chg_en = fast_clock_timing_reg[`DRTC_FAST_ROW_CHG];
  wire spacing_en = fast_clock_timing_reg[`DRTC_FAST_SPACING];

  // Command path: optional one-clock hold before the sequencer
  logic [CTRL_W-1:0] cmd_hold;
  logic cmd_hold_valid;
  wire [CTRL_W-1:0] next_seq_command = cmd_delay_en ? cmd_hold : command_i;
  wire next_seq_valid = cmd_delay_en ? cmd_hold_valid : access_i.start;

  // Access spacing: row change penalty and four-period guard
  logic [2:0] last_row;
  logic last_valid;
  logic [2:0] space_cnt;
  logic stall;
  wire row_changed = last_valid && (access_i.row != last_row);
  wire need_row_pen = row_chg_en && access_i.start && row_changed && access_i.page_hit && !stall;
  wire busy_spacing = spacing_en && (space_cnt != 3'h0);
  wire next_grant = access_i.start && !busy_spacing && !need_row_pen;
  wire [2:0] next_space_cnt = next_grant ? 3'(`DRTC_SPACING_PERIODS - 1) :
    ((space_cnt != 3'h0) ? space_cnt - 3'h1 : 3'h0);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_hold <= '0;
      cmd_hold_valid <= 1'b0;
      seq_command_o <= '0;
      seq_command_valid_o <= 1'b0;
    end else begin
      cmd_hold <= command_i;
      cmd_hold_valid <= access_i.start;
      seq_command_o <= next_seq_command;
      seq_command_valid_o <= next_seq_valid;
    end
  end

  // The penalty is paid once: stall lets the retried start through next cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      space_cnt <= 3'h0;
      stall <= 1'b0;
    end else begin
      space_cnt <= next_space_cnt;
      stall <= need_row_pen;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      access_grant_o <= 1'b0;
    end else begin
      access_grant_o <= next_grant;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_row <= 3'h0;
      last_valid <= 1'b0;
    end else if (next_grant) begin
      last_row <= access_i.row;
      last_valid <= 1'b1;
    end
  end

  // Data and control pipes
  wire [DATA_W-1:0] read_piped;
  wire [DATA_W-1:0] write_piped;
  wire [DATA_W-1:0] write_out;
  wire [CTRL_W-1:0] ctrl_piped;

  drtc_pipe_stage #(.WIDTH(DATA_W)) u_read_pipe (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(pipe_ctrl[`DRTC_PIPE_READ]),
    .data_i(mem_data_in_i),
    .data_o(read_piped)
  );

  drtc_pipe_stage #(.WIDTH(DATA_W)) u_write_pipe (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(pipe_ctrl[`DRTC_PIPE_CMD]),
    .data_i(write_data_i),
    .data_o(write_piped)
  );

  drtc_pipe_stage #(.WIDTH(DATA_W)) u_out_pipe (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(pipe_ctrl[`DRTC_PIPE_OUT]),
    .data_i(write_piped),
    .data_o(write_out)
  );

  drtc_pipe_stage #(.WIDTH(CTRL_W)) u_ctrl_pipe (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(pipe_ctrl[`DRTC_PIPE_CMD]),
    .data_i(mem_ctrl_i),
    .data_o(ctrl_piped)
  );

  drtc_delay_line #(.TAPS(`DRTC_TAP_COUNT)) u_tap (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .enable_i(pipe_ctrl[`DRTC_PIPE_READ]),
    .tap_i(pipe_ctrl[`DRTC_PIPE_DLY_HI:`DRTC_PIPE_DLY_LO]),
    .tap_onehot_o(read_tap_o)
  );

  // Output registers; the early clock select tells the clock tree to use the PLL lead phase
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_cfg_o <= '0;
    end else begin
      row_cfg_o <= query_dec;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row7_cfg_o <= '0;
    end else begin
      row7_cfg_o <= row7_dec;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rcd_clocks_o <= 3'(`DRTC_RCD_DEFAULT);
    end else begin
      rcd_clocks_o <= next_rcd;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      column_latency_o <= 1'b0;
    end else begin
      column_latency_o <= next_latency;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      read_data_o <= '0;
    end else begin
      read_data_o <= read_piped;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_data_out_o <= '0;
    end else begin
      mem_data_out_o <= write_out;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_ctrl_o <= '0;
    end else begin
      mem_ctrl_o <= ctrl_piped;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      early_clock_sel_o <= 1'b0;
    end else begin
      early_clock_sel_o <= pipe_ctrl[`DRTC_PIPE_CMD];
    end
  end
endmodule : drtc_timing_config

// ### drtc_timing_config_assertions.sv
// Checker for the timing configuration block, bound to its ports.
// Assumes configuration changes only through bus_i writes.
`timescale 1ns/100ps
`include "drtc_defines.svh"
module drtc_timing_config_assertions #(
  parameter int DATA_W = 64,
  parameter int CTRL_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire drtc_pkg::drtc_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire drtc_pkg::drtc_access_t access_i,
  input wire logic [DATA_W-1:0] mem_data_in_i,
  input wire logic [DATA_W-1:0] write_data_i,
  input wire logic [CTRL_W-1:0] command_i,
  input wire logic [2:0] rcd_clocks_o,
  input wire logic [CTRL_W-1:0] seq_command_o,
  input wire logic access_grant_o,
  input wire logic [DATA_W-1:0] read_data_o,
  input wire logic [DATA_W-1:0] mem_data_out_o,
  input wire logic [3:0] read_tap_o,
  input wire logic [CTRL_W-1:0] mem_ctrl_i,
  input wire logic [CTRL_W-1:0] mem_ctrl_o,
  input wire logic seq_command_valid_o
);
  import drtc_pkg::*;
  logic [7:0] fast;
  logic [7:0] pipe;
  logic [1:0] quiet;
  wire hit_fast = bus_i.wr && bus_i.addr == `DRTC_OFF_FAST;
  wire hit_pipe = bus_i.wr && bus_i.addr == `DRTC_OFF_PIPE;
  // Derived outputs lag a write, so timing checks wait until it has settled
  wire settled = quiet == 2'h3;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fast <= 8'h00;
      pipe <= 8'h00;
      quiet <= 2'h0;
    end else begin
      fast <= hit_fast ? bus_i.wdata : fast;
      pipe <= hit_pipe ? bus_i.wdata : pipe;
      quiet <= (hit_fast || hit_pipe) ? 2'h0 : (settled ? quiet : quiet + 2'h1);
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_read_idle; !$past(bus_i.rd) |-> rdata_o == 8'h00; endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside slot");
  property p_read_fast; bus_i.rd && bus_i.addr == `DRTC_OFF_FAST |=> rdata_o == (fast & `DRTC_FAST_MASK); endproperty
  a_read_fast: assert property (p_read_fast) else $error("timing register readback");
  property p_rcd; settled |-> rcd_clocks_o == ((fast[7] && fast[6]) ? 3'h2 : 3'h3); endproperty
  a_rcd: assert property (p_rcd) else $error("row to column delay");
  property p_cmd_slow; settled && !fast[2] |-> seq_command_o == $past(command_i, 2); endproperty
  a_cmd_slow: assert property (p_cmd_slow) else $error("delayed command");
  property p_cmd_fast; settled && fast[2] |-> seq_command_o == $past(command_i); endproperty
  a_cmd_fast: assert property (p_cmd_fast) else $error("undelayed command");
  property p_spacing; settled && fast[0] && access_grant_o |=> !access_grant_o [*3]; endproperty
  a_spacing: assert property (p_spacing) else $error("grant inside spacing");
  property p_grant; access_grant_o |-> $past(access_i.start); endproperty
  a_grant: assert property (p_grant) else $error("grant without request");
  property p_read_pipe; settled |-> read_data_o == (pipe[2] ? $past(mem_data_in_i, 2) : $past(mem_data_in_i)); endproperty
  a_read_pipe: assert property (p_read_pipe) else $error("read path lag");
  property p_out_pipe; settled && pipe[1:0] == 2'b01 |-> mem_data_out_o == $past(write_data_i, 2); endproperty
  a_out_pipe: assert property (p_out_pipe) else $error("output path lag");
  property p_tap; settled |-> read_tap_o == (pipe[2] ? 4'h1 << pipe[4:3] : 4'h0); endproperty
  a_tap: assert property (p_tap) else $error("read tap select");
  property p_out_both; settled && pipe[1:0] == 2'b11 |-> mem_data_out_o == $past(write_data_i, 3); endproperty
  a_out_both: assert property (p_out_both) else $error("two stage output lag");
  property p_ctrl_pipe; settled |-> mem_ctrl_o == (pipe[1] ? $past(mem_ctrl_i, 2) : $past(mem_ctrl_i)); endproperty
  a_ctrl_pipe: assert property (p_ctrl_pipe) else $error("control path lag");
  property p_cmd_valid;
    settled |-> seq_command_valid_o == (fast[2] ? $past(access_i.start) : $past(access_i.start, 2));
  endproperty
  a_cmd_valid: assert property (p_cmd_valid) else $error("command valid lag");
  c_spacing: cover property (fast[0] && access_grant_o);
  c_fast_cmd: cover property (settled && fast[2]);
  c_read_pipe: cover property (settled && pipe[2] && pipe[4:3] == 2'h3);
endmodule : drtc_timing_config_assertions
bind drtc_timing_config drtc_timing_config_assertions #(.DATA_W(DATA_W), .CTRL_W(CTRL_W)) u_checker (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o), .access_i(access_i),
  .mem_data_in_i(mem_data_in_i), .write_data_i(write_data_i), .command_i(command_i),
  .rcd_clocks_o(rcd_clocks_o), .seq_command_o(seq_command_o), .access_grant_o(access_grant_o),
  .read_data_o(read_data_o), .mem_data_out_o(mem_data_out_o), .read_tap_o(read_tap_o),
  .mem_ctrl_i(mem_ctrl_i), .mem_ctrl_o(mem_ctrl_o), .seq_command_valid_o(seq_command_valid_o)
);

// ### drtc_row_model.sv
// Behavioural memory rows answering reads on the memory data bus.
// Assumes the controller samples the data on the same clock.
`timescale 1ns/100ps
module drtc_row_model #(
  parameter int DATA_W = 64
) (
  input wire logic clock_i,
  input wire logic [DATA_W-1:0] write_data_i,
  output logic [DATA_W-1:0] read_data_o
);
  logic [DATA_W-1:0] pat = '0;
  // Moves every cycle, so a lost or extra pipe stage cannot match by luck
  always @(posedge clock_i) pat <= {pat[DATA_W-2:0], ~pat[DATA_W-1]} ^ write_data_i;
  assign read_data_o = pat;
endmodule : drtc_row_model

// ### tb.sv
// Self-checking bench for the row and timing configuration block.
// Assumes the checker is bound in and the row model feeds read data.
`timescale 1ns/100ps
module tb;
  import drtc_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  drtc_bus_req_t bus_i = '0;
  drtc_access_t access_i = '0;
  logic [2:0] query_row_i = 3'h0;
  logic [15:0] write_data_i = 16'h0000;
  logic [7:0] command_i = 8'h00;
  logic [7:0] mem_ctrl_i = 8'h00;
  logic [15:0] mem_data_in_i, read_data_o, mem_data_out_o;
  logic [7:0] rdata_o, seq_command_o, mem_ctrl_o;
  drtc_row_cfg_t row_cfg_o, row7_cfg_o;
  logic [2:0] rcd_clocks_o;
  logic [3:0] read_tap_o;
  logic column_latency_o, seq_command_valid_o, access_grant_o, early_clock_sel_o;
  logic [7:0] gsh = 8'h00;
  logic [7:0] addrs [7] = '{8'h6E, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'h48};
  logic [7:0] masks [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC7, 8'h1F, 8'h10};
  int n_fail = 0;
  int checks = 0;
  drtc_timing_config #(.DATA_W(16), .CTRL_W(8)) dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o), .access_i(access_i),
    .query_row_i(query_row_i), .mem_data_in_i(mem_data_in_i), .write_data_i(write_data_i),
    .command_i(command_i), .mem_ctrl_i(mem_ctrl_i), .row_cfg_o(row_cfg_o), .row7_cfg_o(row7_cfg_o),
    .rcd_clocks_o(rcd_clocks_o), .column_latency_o(column_latency_o), .seq_command_o(seq_command_o),
    .seq_command_valid_o(seq_command_valid_o), .access_grant_o(access_grant_o), .read_data_o(read_data_o),
    .mem_data_out_o(mem_data_out_o), .mem_ctrl_o(mem_ctrl_o), .read_tap_o(read_tap_o),
    .early_clock_sel_o(early_clock_sel_o)
  );
  drtc_row_model #(.DATA_W(16)) u_rows (.clock_i(clock_i), .write_data_i(mem_data_out_o), .read_data_o(mem_data_in_i));
  initial forever #5 clock_i = ~clock_i;
  always @(negedge clock_i) gsh <= {gsh[6:0], access_grant_o};
  always @(posedge clock_i) begin
    write_data_i <= 16'($urandom);
    command_i <= 8'($urandom);
    mem_ctrl_i <= 8'($urandom);
  end
  function automatic drtc_row_cfg_t exp_row7(input logic [7:0] lo, hi, dn, bk);
    exp_row7 = '{map_enable: hi[5] || hi[7:6] != 2'b00, sync_mode: hi[5], map_scheme: hi[7:6],
      mem_type: drtc_mem_type_t'(hi[5:4]), top_addr: {hi[3:0], lo}, dens_256: dn[7], four_banks: bk[7]};
  endfunction : exp_row7
  // First request at the top bit; three refusals follow each grant when spacing is on
  function automatic logic [7:0] exp_grants(input int n, input logic sp);
    int gap = 9;
    exp_grants = 8'h00;
    for (int k = n - 1; k >= 0; k--) begin
      if (!sp || gap >= 3) begin
        exp_grants[k] = 1'b1;
        gap = 0;
      end else begin
        gap++;
      end
    end
  endfunction : exp_grants
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_i <= '0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_i <= '0;
    #1;
    check("rdata", rdata_o, exp);
  endtask : reg_rd
  task automatic burst(input logic [2:0] r, input logic h, input int n, input logic [7:0] exp);
    repeat (4) @(posedge clock_i);
    access_i <= '{row_sel: 2'h0, row: r, page_hit: h, start: 1'b1};
    repeat (n) @(posedge clock_i);
    access_i <= '0;
    @(negedge clock_i);
    #1;
    check("grants", gsh & ((8'h1 << n) - 8'h1), exp);
  endtask : burst
  task automatic test_done();
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  initial begin
    logic [7:0] lo, hi, dn, bk, v;
    int i;
    void'($urandom(32'hD3A6));
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    foreach (addrs[k]) reg_rd(addrs[k], 8'h00);
    reg_wr(8'h74, 8'hFF);
    reg_rd(8'h74, 8'h00);
    repeat (24) begin
      i = $urandom_range(6);
      v = 8'($urandom);
      reg_wr(addrs[i], v);
      reg_rd(addrs[i], v & masks[i]);
    end
    for (int k = 0; k < 16; k++) begin
      lo = 8'($urandom);
      hi = {k[3:0], 4'($urandom)};
      dn = 8'($urandom);
      bk = 8'($urandom);
      reg_wr(8'h6E, lo);
      reg_wr(8'h6F, hi);
      reg_wr(8'h70, dn);
      reg_wr(8'h71, bk);
      query_row_i <= 3'(k);
      repeat (3) @(posedge clock_i);
      #1;
      check("row7", row7_cfg_o, exp_row7(lo, hi, dn, bk));
      check("row", {row_cfg_o.dens_256, row_cfg_o.four_banks}, {dn[k[2:0]], bk[k[2:0]]});
    end
    for (int k = 0; k < 8; k++) begin
      v = {k[1:0], 3'h0, k[2], 2'h0};
      lo = {3'h0, ~k[1], 4'h0};
      reg_wr(8'h48, lo);
      reg_wr(8'h72, v);
      repeat (8) @(posedge clock_i);
      #1;
      check("rcd", rcd_clocks_o, (v[7:6] == 2'b11) ? 3'h2 : 3'h3);
      if (v[6]) check("latency", column_latency_o, lo[4]);
    end
    for (int k = 0; k < 32; k++) begin
      reg_wr(8'h73, 8'(k));
      repeat (6) @(posedge clock_i);
      #1;
      check("early", early_clock_sel_o, k[1]);
      check("tap", read_tap_o, k[2] ? 4'h1 << k[4:3] : 4'h0);
    end
    reg_wr(8'h72, 8'h00);
    burst(3'h1, 1'b0, 4, exp_grants(4, 1'b0));
    reg_wr(8'h72, 8'h01);
    burst(3'h2, 1'b1, 5, exp_grants(5, 1'b1));
    reg_wr(8'h72, 8'h02);
    burst(3'h1, 1'b0, 1, 8'h01);
    burst(3'h2, 1'b1, 2, 8'h01);
    burst(3'h2, 1'b1, 1, 8'h01);
    test_done();
  end
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule : tb
